/* core/vic_defs.svh */
// Offsets, reset values and timing counts of the vectored interrupt controller
`ifndef VIC_DEFS_SVH
`define VIC_DEFS_SVH
`define VIC_OFF_SYSCTL 32'h0000FFC4
`define VIC_OFF_SENSE 32'h0000FFC6
`define VIC_OFF_ENABLE 32'h0000FFC7
`define VIC_ADDR_SYSCTL 32'h0003FF10
`define VIC_ADDR_SENSE 32'h0003FF18
`define VIC_ADDR_ENABLE 32'h0003FF1C
`define VIC_ADDR_STATUS 32'h0003FF20
`define VIC_ADDR_CPUCTL 32'h0003FF24
`define VIC_SYSCTL_RESET 8'h09
`define VIC_SENSE_RESET 8'h00
`define VIC_ENABLE_RESET 8'h00
`define VIC_NMI_EDGE_BIT 2
`define VIC_CPU_MASK_BIT 0
`define VIC_CPU_HWSTBY_BIT 1
`define VIC_CPU_SWSTBY_BIT 2
`define VIC_VEC_NMI 6'h03
`define VIC_VEC_EXT_BASE 6'h04
`define VIC_VEC_INT_BASE 6'h0C
`define VIC_DECIDE_EXT 2
`define VIC_DECIDE_INT 1
`endif

/* core/vic_pkg.sv */
// Types shared by the vectored interrupt controller
package vic_pkg;
  typedef enum logic [1:0] {
    VIC_IDLE,
    VIC_DECIDE,
    VIC_PRESENT
  } vic_phase_type;

  typedef struct packed {
    logic [7:0] sysctl;
    logic [7:0] sense;
    logic [7:0] enable;
    logic [2:0] cpuctl;
    logic [7:0] ext_pending;
    logic nmi_pending;
    logic [1:0] nmi_sync;
    logic nmi_prev;
    logic [15:0] ext_sync;
    logic [7:0] ext_prev;
    logic [21:0] int_sync;
    vic_phase_type phase;
    logic [1:0] decide_cnt;
    logic cpu_request;
    logic [5:0] vector;
    logic [6:0] vector_addr;
    logic wake;
    logic bus_sel;
    logic bus_write;
    logic [31:0] bus_addr;
    logic [31:0] hrdata;
  } vic_state_type;
endpackage : vic_pkg

/* core/vic_core.sv */
// Vectored interrupt controller with AHB-Lite register slave
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "vic_defs.svh"
module vic_core #(
  parameter int NUM_EXT = 8,
  parameter int NUM_INT = 22
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic nmi_n,
  input wire logic [NUM_EXT-1:0] ext_request_lines_n,
  input wire logic [NUM_INT-1:0] int_request,
  input wire logic cpu_vector_taken,
  output logic cpu_request,
  output logic [5:0] cpu_vector,
  output logic [6:0] cpu_vector_addr,
  output logic standby_wake
);
  vic_pkg::vic_state_type s_reg;
  vic_pkg::vic_state_type s_next;

  function automatic logic [5:0] vic_ext_vector(input logic [7:0] req);
    vic_ext_vector = 6'h00;
    for (int i = 7; i >= 0; i--) begin
      if (req[i]) begin
        vic_ext_vector = 6'(`VIC_VEC_EXT_BASE + i);
      end
    end
  endfunction : vic_ext_vector

  function automatic logic [5:0] vic_int_vector(input logic [21:0] req);
    vic_int_vector = 6'h00;
    for (int i = 21; i >= 0; i--) begin
      if (req[i]) begin
        vic_int_vector = 6'(`VIC_VEC_INT_BASE + i);
      end
    end
  endfunction : vic_int_vector

  logic mask_bit;
  logic [7:0] ext_level;
  logic [7:0] ext_fall;
  logic [7:0] ext_accept;
  logic [21:0] int_accept;
  logic nmi_edge;
  logic nmi_live;
  logic [5:0] winner;
  logic have_ext;
  logic have_int;
  logic bus_go;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_reg.hrdata;
  assign cpu_request = s_reg.cpu_request;
  assign cpu_vector = s_reg.vector;
  assign cpu_vector_addr = s_reg.vector_addr;
  assign standby_wake = s_reg.wake;

  always_comb begin
    s_next = s_reg;
    mask_bit = s_reg.cpuctl[`VIC_CPU_MASK_BIT];
    nmi_live = !s_reg.cpuctl[`VIC_CPU_HWSTBY_BIT];
    // Synchronisers: first stage feeds only the second; internal requests pass one register stage
    s_next.nmi_sync = {s_reg.nmi_sync[0], nmi_n};
    s_next.nmi_prev = s_reg.nmi_sync[1];
    for (int i = 0; i < 8; i++) begin
      s_next.ext_sync[2*i+1] = s_reg.ext_sync[2*i];
      s_next.ext_sync[2*i] = ext_request_lines_n[i];
      ext_level[i] = !s_reg.ext_sync[2*i+1];
      ext_fall[i] = s_reg.ext_prev[i] && !s_reg.ext_sync[2*i+1];
      s_next.ext_prev[i] = s_reg.ext_sync[2*i+1];
    end
    s_next.int_sync = int_request;
    // Edge chosen by select bit
    nmi_edge = s_reg.sysctl[`VIC_NMI_EDGE_BIT] ?
      (!s_reg.nmi_prev && s_reg.nmi_sync[1]) :
      (s_reg.nmi_prev && !s_reg.nmi_sync[1]);
    if (nmi_edge && nmi_live) begin
      s_next.nmi_pending = 1'b1;
    end
    for (int i = 0; i < 8; i++) begin
      if (s_reg.sense[i]) begin
        if (ext_fall[i] && s_reg.enable[i]) begin
          s_next.ext_pending[i] = 1'b1;
        end
      end else begin
        s_next.ext_pending[i] = ext_level[i] && s_reg.enable[i];
      end
      if (mask_bit && !s_reg.sense[i] && !s_reg.enable[i]) begin
        s_next.ext_pending[i] = 1'b0;
      end
    end
    // Pending edge lines stay eligible after enable drops
    ext_accept = mask_bit ? 8'h00 :
      (s_reg.ext_pending & (s_reg.enable | s_reg.sense));
    int_accept = mask_bit ? 22'h000000 : s_reg.int_sync;
    have_ext = s_reg.nmi_pending || (ext_accept != 8'h00);
    have_int = int_accept != 22'h000000;
    winner = s_reg.nmi_pending ? `VIC_VEC_NMI :
      (ext_accept != 8'h00) ? vic_ext_vector(ext_accept) :
      vic_int_vector(int_accept);
    s_next.wake = s_reg.cpuctl[`VIC_CPU_SWSTBY_BIT] &&
      (s_reg.nmi_pending || (s_reg.ext_pending[2:0] != 3'h0));
    unique case (s_reg.phase)
      vic_pkg::VIC_IDLE: begin
        if (have_ext) begin
          s_next.decide_cnt = 2'(`VIC_DECIDE_EXT - 1);
          s_next.phase = vic_pkg::VIC_DECIDE;
        end else if (have_int) begin
          // Internal sources need a single decision state, so present at once
          s_next.decide_cnt = 2'(`VIC_DECIDE_INT - 1);
          s_next.cpu_request = 1'b1;
          s_next.vector = winner;
          s_next.vector_addr = {winner, 1'b0};
          s_next.phase = vic_pkg::VIC_PRESENT;
        end
      end
      vic_pkg::VIC_DECIDE: begin
        if (!(have_ext || have_int)) begin
          s_next.phase = vic_pkg::VIC_IDLE;
        end else if (s_reg.decide_cnt > 2'd1) begin
          s_next.decide_cnt = s_reg.decide_cnt - 2'd1;
        end else begin
          s_next.cpu_request = 1'b1;
          s_next.vector = winner;
          s_next.vector_addr = {winner, 1'b0};
          s_next.phase = vic_pkg::VIC_PRESENT;
        end
      end
      vic_pkg::VIC_PRESENT: begin
        // Vector follows the current winner until the CPU latches it, and holds only while masked with no nonmaskable pending
        if (cpu_vector_taken) begin
          s_next.cpu_request = 1'b0;
          s_next.phase = vic_pkg::VIC_IDLE;
          if (s_reg.vector == `VIC_VEC_NMI) begin
            s_next.nmi_pending = 1'b0;
          end else if (s_reg.vector < `VIC_VEC_INT_BASE) begin
            s_next.ext_pending[3'(s_reg.vector - `VIC_VEC_EXT_BASE)] = 1'b0;
          end
          s_next.cpuctl[`VIC_CPU_MASK_BIT] = 1'b1;
        end else if (!mask_bit || s_reg.nmi_pending) begin
          s_next.vector = winner;
          s_next.vector_addr = {winner, 1'b0};
        end
      end
      default: s_next.phase = vic_pkg::VIC_IDLE;
    endcase
    // A new request in the take cycle must not be lost: set wins over clear
    for (int i = 0; i < 8; i++) begin
      if (s_reg.enable[i] && (s_reg.sense[i] ? ext_fall[i] : ext_level[i])) begin
        s_next.ext_pending[i] = 1'b1;
      end
    end
    // Edge request arriving at take time stays pending: set wins
    if (nmi_edge && nmi_live && cpu_vector_taken && s_reg.vector == `VIC_VEC_NMI) begin
      s_next.nmi_pending = 1'b1;
    end
    if (s_reg.cpuctl[`VIC_CPU_HWSTBY_BIT]) begin
      s_next.nmi_pending = 1'b0;
    end
    // AHB-Lite: zero wait, data phase write, registered read
    bus_go = hsel && hready && htrans[1];
    s_next.bus_sel = bus_go;
    s_next.bus_write = hwrite;
    s_next.bus_addr = haddr;
    s_next.hrdata = 32'h00000000;
    if (bus_go && !hwrite) begin
      unique case (haddr)
        `VIC_ADDR_SYSCTL: s_next.hrdata = {24'h000000, s_reg.sysctl};
        `VIC_ADDR_SENSE: s_next.hrdata = {24'h000000, s_reg.sense};
        `VIC_ADDR_ENABLE: s_next.hrdata = {24'h000000, s_reg.enable};
        `VIC_ADDR_STATUS: s_next.hrdata = {15'h0000, s_reg.nmi_pending,
          s_reg.ext_pending, s_reg.cpu_request, 1'b0, s_reg.vector};
        `VIC_ADDR_CPUCTL: s_next.hrdata = {29'h00000000, s_reg.cpuctl};
        default: s_next.hrdata = 32'h00000000;
      endcase
    end
    if (s_reg.bus_sel && s_reg.bus_write) begin
      unique case (s_reg.bus_addr)
        `VIC_ADDR_SYSCTL: s_next.sysctl = hwdata[7:0] | 8'h08;
        `VIC_ADDR_SENSE: s_next.sense = hwdata[7:0];
        `VIC_ADDR_ENABLE: s_next.enable = hwdata[7:0];
        `VIC_ADDR_CPUCTL: s_next.cpuctl = hwdata[2:0];
        default: s_next.cpuctl = s_next.cpuctl;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
      s_reg.sysctl <= `VIC_SYSCTL_RESET;
      s_reg.sense <= `VIC_SENSE_RESET;
      s_reg.enable <= `VIC_ENABLE_RESET;
      s_reg.nmi_sync <= 2'h3;
      s_reg.nmi_prev <= 1'b1;
      s_reg.ext_sync <= 16'hFFFF;
      s_reg.ext_prev <= 8'hFF;
      s_reg.phase <= vic_pkg::VIC_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  sequence vic_present_seq;
    cpu_request && !cpu_vector_taken;
  endsequence

  // Second decision state, or the request vanished before it
  sequence vic_ext_decide_seq;
    !cpu_request ##1 (cpu_request || s_reg.phase == vic_pkg::VIC_IDLE);
  endsequence

  a_vector_table_addr: assert property (@(posedge hclk) disable iff (!hresetn)
    cpu_request |-> cpu_vector_addr == {cpu_vector, 1'b0})
    else $error("vector address not twice vector");
  a_nmi_vector_num: assert property (@(posedge hclk) disable iff (!hresetn)
    (cpu_request && s_reg.nmi_pending && !cpu_vector_taken) |=>
      !cpu_request || cpu_vector == `VIC_VEC_NMI)
    else $error("nonmaskable not vector 3");
  a_ext_vector_range: assert property (@(posedge hclk) disable iff (!hresetn)
    (cpu_request && !s_reg.nmi_pending && ext_accept[0] && !cpu_vector_taken) |=>
      !cpu_request || cpu_vector == 6'h04)
    else $error("line 0 not top priority");
  a_mask_holds_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (mask_bit && s_reg.phase == vic_pkg::VIC_IDLE && !s_reg.nmi_pending) |=> !cpu_request)
    else $error("masked request presented");
  a_request_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    vic_present_seq |=> cpu_request && $stable(cpu_vector) || !mask_bit || cpu_vector == 6'h03)
    else $error("request dropped before taken");
  a_take_sets_mask: assert property (@(posedge hclk) disable iff (!hresetn)
    (cpu_request && cpu_vector_taken) |=> mask_bit && !cpu_request)
    else $error("mask not set on take");
  a_level_pending: assert property (@(posedge hclk) disable iff (!hresetn)
    (!s_reg.sense[1] && s_reg.enable[1] && !s_reg.ext_sync[3]) |=> s_reg.ext_pending[1])
    else $error("low level not pending");
  a_clear_rule: assert property (@(posedge hclk) disable iff (!hresetn)
    (mask_bit && !s_reg.sense[2] && !s_reg.enable[2]) |=> !s_reg.ext_pending[2])
    else $error("pending not cleared");
  a_int_decide_one: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_reg.phase == vic_pkg::VIC_IDLE && have_int && !have_ext && !cpu_request)
      |=> cpu_request)
    else $error("internal decision not one cycle");
  a_reset_enable: assert property (@(posedge hclk)
    $rose(hresetn) |-> s_reg.enable == 8'h00)
    else $error("enable not zero after reset");
  a_ext_decide_two: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_reg.phase == vic_pkg::VIC_IDLE && have_ext) |=> vic_ext_decide_seq)
    else $error("external decision not two cycles");
  a_edge_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_reg.sense[3] && s_reg.enable[3] && ext_fall[3]) |=> s_reg.ext_pending[3])
    else $error("enabled falling edge not latched");
  a_disabled_no_latch: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_reg.sense[3] && !s_reg.enable[3] && !s_reg.ext_pending[3]) |=> !s_reg.ext_pending[3])
    else $error("disabled line latched a request");
  a_nmi_ignores_mask: assert property (@(posedge hclk) disable iff (!hresetn)
    (nmi_edge && nmi_live) |=> s_reg.nmi_pending)
    else $error("nonmaskable edge not latched");
  a_hwstby_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
    s_reg.cpuctl[`VIC_CPU_HWSTBY_BIT] |=> !s_reg.nmi_pending)
    else $error("nonmaskable pending in hardware standby");
  a_wake_lines: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_reg.cpuctl[`VIC_CPU_SWSTBY_BIT] && s_reg.ext_pending[0]) |=> standby_wake)
    else $error("line 0 did not wake");
  a_wake_nmi: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_reg.cpuctl[`VIC_CPU_SWSTBY_BIT] && s_reg.nmi_pending) |=> standby_wake)
    else $error("nonmaskable did not wake");
endmodule : vic_core
`default_nettype wire

/* tb/vic_cpu_model.sv */
// CPU side model that takes presented vectors after an instruction wait
`timescale 1ns/10ps
`default_nettype none
module vic_cpu_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cpu_request,
  input wire logic [5:0] cpu_vector,
  input wire logic slow,
  output logic cpu_vector_taken,
  output logic [5:0] taken_vector
);
  int wait_cnt;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_vector_taken <= 1'b0;
      taken_vector <= 6'h00;
      wait_cnt <= 0;
    end else begin
      cpu_vector_taken <= 1'b0;
      // Cool down so a request still dropping is not taken twice
      if (wait_cnt < 0) begin
        wait_cnt <= wait_cnt + 1;
      end else if (cpu_request === 1'b1) begin
        // Instruction end comes after 2 or 13 states
        if (wait_cnt >= (slow ? 13 : 2)) begin
          cpu_vector_taken <= 1'b1;
          taken_vector <= cpu_vector;
          wait_cnt <= -3;
        end else begin
          wait_cnt <= wait_cnt + 1;
        end
      end
    end
  end
endmodule : vic_cpu_model
`default_nettype wire

/* tb/vic_core_bench.sv */
// Self-checking bench of the vectored interrupt controller
`timescale 1ns/10ps
`default_nettype none
`include "vic_defs.svh"
module vic_core_bench;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, nmi_n, taken, req, slow, wake;
  logic [31:0] haddr, hwdata, hrdata, q, seed;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] ext_n;
  logic [21:0] int_req;
  logic [5:0] vec, tvec;
  logic [6:0] vaddr;
  int bad_count, n_compared, cyc, lat, lat_ext, r;
  assign hready = hreadyout;
  vic_core i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .nmi_n(nmi_n), .ext_request_lines_n(ext_n),
    .int_request(int_req), .cpu_vector_taken(taken), .cpu_request(req), .cpu_vector(vec),
    .cpu_vector_addr(vaddr), .standby_wake(wake));
  vic_cpu_model i_cpu (.hclk(hclk), .hresetn(hresetn), .cpu_request(req), .cpu_vector(vec),
    .slow(slow), .cpu_vector_taken(taken), .taken_vector(tvec));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= a; hwrite <= wr; htrans <= 2'h2; hsize <= 3'h2;
    // Only the bench timeout ends a wait for the slave
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk({31'h0, hresp}, 32'h0, "resp");
  endtask : bus
  task automatic cycles(input int n);
    repeat (n) @(posedge hclk);
  endtask : cycles
  function automatic logic [5:0] exp_vec(input logic nmi, input logic [7:0] e, input logic [21:0] i);
    if (nmi) return 6'h03;
    for (int k = 0; k < 8; k++) if (e[k]) return 6'(4 + k);
    for (int k = 0; k < 22; k++) if (i[k]) return 6'(12 + k);
    return 6'h00;
  endfunction : exp_vec
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xorshift
  task automatic wait_req(input logic [5:0] e);
    lat = 0;
    while (req !== 1'b1 && lat < 40) begin
      @(posedge hclk);
      lat++;
    end
    @(posedge hclk);
    chk({req, vec, vaddr}, {1'b1, e, e, 1'b0}, "vector");
    for (int k = 0; k < 40 && req === 1'b1; k++) @(posedge hclk);
    chk(tvec, e, "taken");
    bus(1'b0, `VIC_ADDR_CPUCTL, 0);
    chk(q[0], 1'b1, "mask after take");
  endtask : wait_req
  task automatic no_req();
    int s;
    s = 0;
    repeat (20) begin
      @(posedge hclk);
      s += (req !== 1'b0);
    end
    chk(s, 0, "stray request");
  endtask : no_req
  task automatic pulse(input int n);
    ext_n[n] <= 1'b0;
    cycles(4);
    ext_n[n] <= 1'b1;
    cycles(4);
  endtask : pulse
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
    hwdata = 0; nmi_n = 1'b1; ext_n = 8'hFF; int_req = 0; slow = 1'b0;
    seed = 32'hB52C07A5;
    cycles(12);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, `VIC_ADDR_SYSCTL, 0); chk(q[7:0], 8'h09, "sysctl");
    bus(1'b0, `VIC_ADDR_SENSE, 0); chk(q[7:0], 8'h00, "sense");
    bus(1'b0, `VIC_ADDR_ENABLE, 0); chk(q[7:0], 8'h00, "enable");
    bus(1'b0, 32'h0003FF40, 0); chk(q, 0, "unmapped");
    $display("registers done");
    bus(1'b1, `VIC_ADDR_ENABLE, 32'hFF);
    for (int n = 0; n < 8; n++) begin
      slow <= n[0];
      bus(1'b1, `VIC_ADDR_CPUCTL, 0);
      ext_n <= ~(8'hFF << n);
      wait_req(exp_vec(1'b0, 8'hFF << n, 0));
      ext_n <= 8'hFF;
    end
    $display("priority done");
    seed = xorshift(seed);
    r = seed % 8;
    bus(1'b1, `VIC_ADDR_ENABLE, 0); bus(1'b1, `VIC_ADDR_CPUCTL, 0);
    ext_n[r] <= 1'b0;
    no_req();
    bus(1'b1, `VIC_ADDR_ENABLE, 32'hFF); bus(1'b1, `VIC_ADDR_CPUCTL, 1);
    no_req();
    bus(1'b1, `VIC_ADDR_CPUCTL, 0);
    wait_req(6'(4 + r));
    lat_ext = lat;
    ext_n <= 8'hFF;
    $display("gating done");
    bus(1'b1, `VIC_ADDR_SENSE, 32'h08); bus(1'b1, `VIC_ADDR_ENABLE, 32'h08);
    bus(1'b1, `VIC_ADDR_CPUCTL, 1);
    pulse(3);
    bus(1'b1, `VIC_ADDR_ENABLE, 0); bus(1'b1, `VIC_ADDR_CPUCTL, 0);
    wait_req(6'h07);
    bus(1'b1, `VIC_ADDR_CPUCTL, 0);
    pulse(3);
    no_req();
    bus(1'b1, `VIC_ADDR_ENABLE, 32'h08); bus(1'b1, `VIC_ADDR_CPUCTL, 1);
    pulse(3);
    bus(1'b1, `VIC_ADDR_ENABLE, 0); bus(1'b1, `VIC_ADDR_SENSE, 0);
    bus(1'b1, `VIC_ADDR_SENSE, 32'h08); bus(1'b1, `VIC_ADDR_CPUCTL, 0);
    no_req();
    $display("edge done");
    bus(1'b1, `VIC_ADDR_CPUCTL, 1);
    nmi_n <= 1'b0; wait_req(`VIC_VEC_NMI);
    nmi_n <= 1'b1; no_req();
    bus(1'b1, `VIC_ADDR_SYSCTL, 32'h0D);
    nmi_n <= 1'b0; no_req();
    nmi_n <= 1'b1; wait_req(`VIC_VEC_NMI);
    bus(1'b1, `VIC_ADDR_CPUCTL, 3);
    nmi_n <= 1'b0; cycles(4); nmi_n <= 1'b1;
    no_req();
    bus(1'b1, `VIC_ADDR_SYSCTL, 32'h09);
    $display("nonmaskable done");
    seed = xorshift(seed);
    r = seed % 22;
    bus(1'b1, `VIC_ADDR_CPUCTL, 1);
    int_req <= 22'(1) << r;
    no_req();
    bus(1'b1, `VIC_ADDR_CPUCTL, 0);
    wait_req(6'(12 + r));
    int_req <= 22'h000001;
    cycles(2);
    bus(1'b1, `VIC_ADDR_CPUCTL, 0);
    wait_req(6'h0C);
    chk(lat < lat_ext, 1, "internal faster");
    chk(lat_ext - lat, `VIC_DECIDE_EXT - `VIC_DECIDE_INT, "decision states");
    int_req <= 0;
    $display("internal done");
    bus(1'b1, `VIC_ADDR_ENABLE, 32'hFF); bus(1'b1, `VIC_ADDR_CPUCTL, 5);
    ext_n[seed % 3] <= 1'b0;
    cycles(10);
    chk(wake, 1'b1, "wake");
    ext_n <= 8'hEF;
    cycles(10);
    chk(wake, 1'b0, "no wake");
    $display("standby done");
    final_report();
  end
endmodule : vic_core_bench
`default_nettype wire
